// File: verilog/sqt_pkg.sv
// Purpose: constants for the switch port qos and tag control register bank
// Assumes: classic wishbone, 32-bit data, byte addresses = 4 * index
// Notes: register indices are kept as printed; byte address is four times
package sqt_pkg;
    localparam int SQT_NPORT = 3;
    localparam logic [7:0] SQT_IDX_XCVR_ADDR = 8'h0f;
    localparam logic [7:0] SQT_IDX_PORT1_CTRL = 8'h10;
    localparam logic [7:0] SQT_IDX_PORT2_CTRL = 8'h20;
    localparam logic [7:0] SQT_IDX_PORT3_CTRL = 8'h30;
    localparam logic [7:0] SQT_IDX_MAP_LO = 8'h0c;
    localparam logic [7:0] SQT_IDX_MAP_HI = 8'h0d;
    localparam logic [7:0] SQT_IDX_PORT1_DTAG = 8'h13;
    localparam logic [7:0] SQT_IDX_PORT2_DTAG = 8'h23;
    localparam logic [7:0] SQT_IDX_PORT3_DTAG = 8'h33;
    localparam logic [7:0] SQT_IDX_PORT1_STAT = 8'h1f;
    localparam logic [7:0] SQT_IDX_PORT2_STAT = 8'h2f;
    localparam logic [7:0] SQT_IDX_PORT3_STAT = 8'h3f;
    localparam logic [7:0] SQT_IDX_RESERVED_MASK = 8'h00;
    localparam logic [4:0] SQT_XCVR_ADDR_RST = 5'h01;
    localparam logic [4:0] SQT_XCVR_ADDR_NA0 = 5'h00;
    localparam logic [4:0] SQT_XCVR_ADDR_NA1 = 5'h1e;
    localparam logic [4:0] SQT_XCVR_ADDR_NA2 = 5'h1f;
    localparam int SQT_XCVR_ADDR_LSB = 3;
    localparam logic [2:0] SQT_XCVR_RSVD_VAL = 3'h0;
    localparam logic [7:0] SQT_CTRL_RST = 8'h00;
    localparam logic [7:0] SQT_MAP_LO_RST = 8'h50;
    localparam logic [7:0] SQT_MAP_HI_RST = 8'hfa;
    localparam logic [7:0] SQT_DTAG_RST = 8'h00;
    localparam int SQT_BIT_STORM = 7;
    localparam int SQT_BIT_DSCP = 6;
    localparam int SQT_BIT_DOT1P = 5;
    localparam int SQT_BIT_PPRIO_HI = 4;
    localparam int SQT_BIT_PPRIO_LO = 3;
    localparam int SQT_BIT_TAG_INS = 2;
    localparam int SQT_BIT_TAG_REM = 1;
    localparam int SQT_BIT_MULTIQ = 0;
    typedef enum logic [0:0] {SQT_IDLE, SQT_ACKED} sqt_bus_state_t;
endpackage : sqt_pkg

// File: verilog/sqt_regs.sv
// Purpose: register bank and per-port ingress/egress decisions
// Assumes: classic wishbone slave, one wait state, ack lasts one cycle
// Notes: classification inputs are per-port packed vectors, index p*w
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
module sqt_regs
    import sqt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // transceiver management addresses
    output logic [4:0] xcvr1_mgmt_addr,
    output logic [4:0] xcvr2_mgmt_addr,
    output logic xcvr_addr_valid,
    // ingress classification, per port
    input wire logic [2:0] rx_is_ip,
    input wire logic [2:0] rx_dscp_hit,
    input wire logic [5:0] rx_dscp_prio,
    input wire logic [2:0] rx_tagged,
    input wire logic [8:0] rx_user_prio,
    output logic [5:0] rx_queue_prio,
    output logic [2:0] rx_storm_protect,
    output logic [35:0] port_default_vlan_id,
    output logic [8:0] port_default_prio,
    // egress, per port
    input wire logic [2:0] tx_arrived_tagged,
    output logic [2:0] tx_insert_tag,
    output logic [2:0] tx_remove_tag,
    output logic [2:0] tx_multi_queue,
    output logic [5:0] tx_queue_sel
);

    typedef struct packed {
        sqt_bus_state_t bus;
        logic [31:0] rdata;
        logic [4:0] xcvr_addr;
        logic [7:0] map_lo;
        logic [7:0] map_hi;
        logic [2:0][7:0] ctrl;
        logic [2:0][7:0] dtag;
    } sqt_state_t;

    sqt_state_t state_reg;
    sqt_state_t state_next;
    logic [7:0] widx;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [15:0] prio_map;
    logic [2:0][7:0] stat;
    logic [2:0][1:0] qprio;

    assign widx = wb_adr_i[9:2];
    assign wbyte = wb_dat_i[7:0];
    assign prio_map = {state_reg.map_hi, state_reg.map_lo};

    // per-port decisions; combinational so a write acts at once
    genvar p;
    generate
        for (p = 0; p < SQT_NPORT; p++) begin : g_port
            logic [7:0] c;
            logic [1:0] dot1p_q;
            logic [1:0] dscp_q;
            logic use_dot1p;
            logic use_dscp;
            assign c = state_reg.ctrl[p];
            assign dot1p_q = prio_map[rx_user_prio[p*3 +: 3]*2 +: 2];
            assign dscp_q = rx_dscp_prio[p*2 +: 2];
            assign use_dot1p = c[SQT_BIT_DOT1P] && rx_tagged[p];
            assign use_dscp = c[SQT_BIT_DSCP] && rx_is_ip[p]
                && rx_dscp_hit[p];
            // one continuous driver per element keeps the loop single-driven
            assign qprio[p] = (use_dot1p || use_dscp)
                ? ((use_dot1p ? dot1p_q : 2'b00)
                | (use_dscp ? dscp_q : 2'b00))
                : c[SQT_BIT_PPRIO_HI:SQT_BIT_PPRIO_LO];
            assign rx_queue_prio[p*2 +: 2] = qprio[p];
            assign rx_storm_protect[p] = c[SQT_BIT_STORM];
            assign tx_insert_tag[p] = c[SQT_BIT_TAG_INS]
                && !tx_arrived_tagged[p];
            assign tx_remove_tag[p] = c[SQT_BIT_TAG_REM]
                && tx_arrived_tagged[p];
            assign tx_multi_queue[p] = c[SQT_BIT_MULTIQ];
            // single queue flattens every class to queue 0
            assign tx_queue_sel[p*2 +: 2] =
                c[SQT_BIT_MULTIQ] ? qprio[p] : 2'b00;
            // default tag byte is the tag's high byte: pcp, cfi, vid[11:8]
            assign port_default_prio[p*3 +: 3] = state_reg.dtag[p][7:5];
            assign port_default_vlan_id[p*12 +: 12] =
                {state_reg.dtag[p][3:0], 8'h00};
            assign stat[p] = {5'h00, qprio[p], rx_storm_protect[p]};
        end
    endgenerate

    assign xcvr1_mgmt_addr = state_reg.xcvr_addr;
    assign xcvr2_mgmt_addr = state_reg.xcvr_addr + 5'h01;
    assign xcvr_addr_valid = state_reg.xcvr_addr != SQT_XCVR_ADDR_NA0
        && state_reg.xcvr_addr != SQT_XCVR_ADDR_NA1
        && state_reg.xcvr_addr != SQT_XCVR_ADDR_NA2;
    assign wb_ack_o = state_reg.bus == SQT_ACKED;
    assign wb_dat_o = state_reg.rdata;

    // read mux; unmapped indices read zero
    always_comb begin
        rbyte = 8'h00;
        if (widx == SQT_IDX_XCVR_ADDR) begin
            rbyte = {state_reg.xcvr_addr, SQT_XCVR_RSVD_VAL};
        end else if (widx == SQT_IDX_MAP_LO) begin
            rbyte = state_reg.map_lo;
        end else if (widx == SQT_IDX_MAP_HI) begin
            rbyte = state_reg.map_hi;
        end else if (widx == SQT_IDX_PORT1_CTRL) begin
            rbyte = state_reg.ctrl[0];
        end else if (widx == SQT_IDX_PORT2_CTRL) begin
            rbyte = state_reg.ctrl[1];
        end else if (widx == SQT_IDX_PORT3_CTRL) begin
            rbyte = state_reg.ctrl[2];
        end else if (widx == SQT_IDX_PORT1_DTAG) begin
            rbyte = state_reg.dtag[0];
        end else if (widx == SQT_IDX_PORT2_DTAG) begin
            rbyte = state_reg.dtag[1];
        end else if (widx == SQT_IDX_PORT3_DTAG) begin
            rbyte = state_reg.dtag[2];
        end else if (widx == SQT_IDX_PORT1_STAT) begin
            rbyte = stat[0];
        end else if (widx == SQT_IDX_PORT2_STAT) begin
            rbyte = stat[1];
        end else if (widx == SQT_IDX_PORT3_STAT) begin
            rbyte = stat[2];
        end
    end

    // one wait state: ack in the cycle after the request is seen
    always_comb begin
        state_next = state_reg;
        case (state_reg.bus)
            SQT_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    state_next.bus = SQT_ACKED;
                    state_next.rdata = {24'h00_0000, rbyte};
                    if (wb_we_i && wb_sel_i[0]) begin
                        if (widx == SQT_IDX_XCVR_ADDR) begin
                            // reserved low bits are not stored
                            state_next.xcvr_addr =
                                wbyte[7:SQT_XCVR_ADDR_LSB];
                        end else if (widx == SQT_IDX_MAP_LO) begin
                            state_next.map_lo = wbyte;
                        end else if (widx == SQT_IDX_MAP_HI) begin
                            state_next.map_hi = wbyte;
                        end else if (widx == SQT_IDX_PORT1_CTRL) begin
                            state_next.ctrl[0] = wbyte;
                        end else if (widx == SQT_IDX_PORT2_CTRL) begin
                            state_next.ctrl[1] = wbyte;
                        end else if (widx == SQT_IDX_PORT3_CTRL) begin
                            state_next.ctrl[2] = wbyte;
                        end else if (widx == SQT_IDX_PORT1_DTAG) begin
                            state_next.dtag[0] = wbyte;
                        end else if (widx == SQT_IDX_PORT2_DTAG) begin
                            state_next.dtag[1] = wbyte;
                        end else if (widx == SQT_IDX_PORT3_DTAG) begin
                            state_next.dtag[2] = wbyte;
                        end
                    end
                end
            end
            SQT_ACKED: begin
                state_next.bus = SQT_IDLE;
            end
            default: begin
                state_next.bus = SQT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg.bus <= SQT_IDLE;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.xcvr_addr <= SQT_XCVR_ADDR_RST;
            state_reg.map_lo <= SQT_MAP_LO_RST;
            state_reg.map_hi <= SQT_MAP_HI_RST;
            state_reg.ctrl <= {SQT_CTRL_RST, SQT_CTRL_RST, SQT_CTRL_RST};
            state_reg.dtag <= {SQT_DTAG_RST, SQT_DTAG_RST, SQT_DTAG_RST};
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : sqt_regs

// File: tb/sqt_regs_properties.sv
// Purpose: port-level checks of the qos/tag register bank
// Assumes: ack one cycle after the taking edge, one-cycle pulse
// Notes: sees only top ports, so control bits are checked via outputs
`timescale 1ns/1ps
module sqt_props
    import sqt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // transceiver addresses
    input wire logic [4:0] xcvr1_mgmt_addr,
    input wire logic [4:0] xcvr2_mgmt_addr,
    input wire logic xcvr_addr_valid,
    // ingress
    input wire logic [2:0] rx_is_ip,
    input wire logic [2:0] rx_dscp_hit,
    input wire logic [5:0] rx_dscp_prio,
    input wire logic [2:0] rx_tagged,
    input wire logic [8:0] rx_user_prio,
    input wire logic [5:0] rx_queue_prio,
    input wire logic [2:0] rx_storm_protect,
    input wire logic [35:0] port_default_vlan_id,
    input wire logic [8:0] port_default_prio,
    // egress
    input wire logic [2:0] tx_arrived_tagged,
    input wire logic [2:0] tx_insert_tag,
    input wire logic [2:0] tx_remove_tag,
    input wire logic [2:0] tx_multi_queue,
    input wire logic [5:0] tx_queue_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("no ack");
    a_xcvr_next: assert property (xcvr2_mgmt_addr == xcvr1_mgmt_addr + 5'h01)
        else $error("port 2 address");
    a_xcvr_valid: assert property (xcvr_addr_valid == !(xcvr1_mgmt_addr
        inside {5'h00, 5'h1e, 5'h1f})) else $error("valid flag");
    a_rsvd_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:2] ==
        SQT_IDX_XCVR_ADDR |-> wb_dat_o[2:0] == 3'h0) else $error("rsvd");
    // storm enable may only move on the edge that took a write
    a_storm_write: assert property ($changed(rx_storm_protect) |->
        wb_ack_o && wb_we_i) else $error("storm moved");
    a_insert_untag: assert property ((tx_insert_tag & tx_arrived_tagged)
        == 3'h0) else $error("insert on tagged");
    a_remove_tagged: assert property ((tx_remove_tag & ~tx_arrived_tagged)
        == 3'h0) else $error("remove on untagged");
    a_queue_follow: assert property (tx_multi_queue[0] |->
        tx_queue_sel[1:0] == rx_queue_prio[1:0]) else $error("queue");
endmodule : sqt_props

// File: tb/testbench.sv
// Purpose: random and corner checks of the qos/tag register bank
// Assumes: bench keeps its own copy of the 802.1p map and control bytes
// Notes: wishbone master waits on ack with a bounded count
`timescale 1ns/1ps
module testbench;
    import sqt_pkg::*;
    logic clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, ack;
    logic [9:0] adr = '0;
    logic [31:0] dat = '0, q, rd;
    logic [2:0] ip = '0, hit = '0, tg = '0, atg = '0, ins, rem, mq, stm;
    logic [5:0] dp = '0, qp, qs;
    logic [8:0] up = '0, dpr;
    logic [4:0] x1, x2, a;
    logic vld;
    logic [3:0] sel = '0;
    logic [1:0] e;
    logic [35:0] dvid;
    logic [15:0] pm = {SQT_MAP_HI_RST, SQT_MAP_LO_RST};
    logic [7:0] c, ctl [3], dtg [3];
    logic [31:0] seed = 32'h0000_0047;
    int num_errors = 0, checked = 0;
    sqt_regs dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .xcvr1_mgmt_addr(x1),
        .xcvr2_mgmt_addr(x2), .xcvr_addr_valid(vld), .rx_is_ip(ip),
        .rx_dscp_hit(hit), .rx_dscp_prio(dp), .rx_tagged(tg),
        .rx_user_prio(up), .rx_queue_prio(qp), .rx_storm_protect(stm),
        .port_default_vlan_id(dvid), .port_default_prio(dpr),
        .tx_arrived_tagged(atg), .tx_insert_tag(ins), .tx_remove_tag(rem),
        .tx_multi_queue(mq), .tx_queue_sel(qs));
    initial begin
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // classifier result: or of the hits overrides the port value
    function automatic logic [1:0] exp_q(logic [7:0] k, logic i, h, t,
        logic [1:0] d, logic [2:0] u, logic [15:0] m);
        logic ds, dt;
        ds = k[6] & i & h;
        dt = k[5] & t;
        if (ds | dt) return (ds ? d : 2'h0) | (dt ? m[2*u+:2] : 2'h0);
        return k[4:3];
    endfunction : exp_q
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task wb(input logic w, input logic [9:0] ad, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, sel, adr, dat} <= {2'b11, w, 4'h1, ad, 24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rd;
        {cyc, stb} <= 2'b00;
        if (n >= 20) num_errors++;
    endtask : wb
    task report_and_stop;
        if (num_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    initial begin
        #2_000_000;
        num_errors++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 0;
        wb(0, 10'h03c, 0);
        chk(q, 32'h0000_0008);
        for (int p = 1; p < 4; p++) begin
            wb(0, 10'(p << 6), 0);
            chk(q, {24'h0, SQT_CTRL_RST});
            wb(0, 10'((p << 6) | 12), 0);
            chk(q, {24'h0, SQT_DTAG_RST});
            ctl[p-1] = SQT_CTRL_RST;
            dtg[p-1] = SQT_DTAG_RST;
        end
        wb(1, 10'h3f8, 8'hff);
        wb(0, 10'h3f8, 0);
        chk(q, 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            // the codes with no transceiver behind them come first
            a = (i < 4) ? 5'(20'he_ffc0 >> (5 * i)) : 5'(rnd());
            wb(1, 10'h03c, {a, SQT_XCVR_RSVD_VAL});
            wb(0, 10'h03c, 0);
            chk(q, {24'h0, a, 3'h0});
            chk(x1, a);
            chk(x2, 5'(a + 5'h01));
            chk(vld, !(a inside {5'h00, 5'h1e, 5'h1f}));
        end
        for (int i = 0; i < 40; i++) begin
            c = 8'(rnd()) | ((i < 6) ? 8'h60 : 8'h00);
            ctl[i % 3] = c;
            wb(1, 10'((i % 3 + 1) << 6), c);
            wb(0, 10'((i % 3 + 1) << 6), 0);
            chk(q, {24'h0, c});
            dtg[i % 3] = 8'(rnd());
            wb(1, 10'((i % 3 + 1) << 6 | 12), dtg[i % 3]);
            wb(0, 10'((i % 3 + 1) << 6 | 12), 0);
            chk(q, {24'h0, dtg[i % 3]});
            if (i % 10 == 9) begin
                pm = 16'(rnd());
                wb(1, 10'h030, pm[7:0]);
                wb(1, 10'h034, pm[15:8]);
                wb(0, 10'h030, 0);
                chk(q, {24'h0, pm[7:0]});
                wb(0, 10'h034, 0);
                chk(q, {24'h0, pm[15:8]});
            end
            {ip, hit, tg, atg, dp, up} <= (i < 6) ? {9'h1ff, 3'(rnd()),
                15'(rnd())} : 27'(rnd());
            @(posedge clk);
            for (int p = 0; p < 3; p++) begin
                e = exp_q(ctl[p], ip[p], hit[p], tg[p], dp[2*p+:2],
                    up[3*p+:3], pm);
                chk(stm[p], ctl[p][7]);
                chk(mq[p], ctl[p][0]);
                chk(qp[2*p+:2], e);
                chk(qs[2*p+:2], ctl[p][0] ? e : 2'h0);
                chk(ins[p], ctl[p][2] & !atg[p]);
                chk(rem[p], ctl[p][1] & atg[p]);
                chk(dpr[3*p+:3], dtg[p][7:5]);
                chk(dvid[12*p+:12], {dtg[p][3:0], 8'h00});
            end
        end
        report_and_stop;
    end
endmodule : testbench
bind sqt_regs sqt_props u_props (.clk(clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .xcvr1_mgmt_addr(xcvr1_mgmt_addr), .xcvr2_mgmt_addr(xcvr2_mgmt_addr),
    .xcvr_addr_valid(xcvr_addr_valid), .rx_is_ip(rx_is_ip),
    .rx_dscp_hit(rx_dscp_hit), .rx_dscp_prio(rx_dscp_prio),
    .rx_tagged(rx_tagged), .rx_user_prio(rx_user_prio),
    .rx_queue_prio(rx_queue_prio), .rx_storm_protect(rx_storm_protect),
    .port_default_vlan_id(port_default_vlan_id),
    .port_default_prio(port_default_prio),
    .tx_arrived_tagged(tx_arrived_tagged), .tx_insert_tag(tx_insert_tag),
    .tx_remove_tag(tx_remove_tag), .tx_multi_queue(tx_multi_queue),
    .tx_queue_sel(tx_queue_sel));
